// ==== hw/esrg_defines.svh ====
// Register offsets, field positions and reset values for the range guard
`ifndef ESRG_DEFINES_SVH
`define ESRG_DEFINES_SVH
`define ESRG_OFF_TOP        12'h000
`define ESRG_OFF_ERR        12'h004
`define ESRG_OFF_CTRL       12'h008
`define ESRG_OFF_LOCK       12'h00C
`define ESRG_OFF_IRQ_STAT   12'h010
`define ESRG_OFF_IRQ_EN     12'h014
`define ESRG_OFF_IRQ_CLR    12'h018
`define ESRG_TOP_RESET      4'h1
`define ESRG_ERR_BIT        7
`define ESRG_CTRL_EN        0
`define ESRG_CTRL_SZ_LO     1
`define ESRG_CTRL_SZ_HI     2
`define ESRG_CTRL_GEN       3
`define ESRG_CTRL_OPEN      4
`define ESRG_LOCK_BIT       0
`define ESRG_SZ_512K        24'h080000
`define ESRG_SZ_1M          24'h100000
`define ESRG_SZ_2M          24'h200000
`define ESRG_SZ_4M          24'h400000
`define ESRG_EV_CPU         0
`define ESRG_EV_IO          1
`endif

// ==== hw/esrg_pkg.sv ====
// Types shared by the range guard
package esrg_pkg;
   typedef enum logic [1:0] {
      ESRG_SZ_512K_E,
      ESRG_SZ_1M_E,
      ESRG_SZ_2M_E,
      ESRG_SZ_4M_E
   } esrg_size_t;
endpackage : esrg_pkg

// ==== hw/esrg_decode.sv ====
// Combinational window decode for the extended SMM region
`include "esrg_defines.svh"
module esrg_decode
   import esrg_pkg::*;
(
   input  wire logic [39:0] addr,
   input  wire logic [3:0]  top,
   input  wire esrg_size_t  size_sel,
   input  wire logic        enable,
   output logic             hit
);
   logic [32:0] top_addr;
   logic [32:0] base_addr;
   logic [32:0] size_bytes;

   always_comb begin
      case (size_sel) // [RQ3] [RQ11]
         ESRG_SZ_512K_E: size_bytes = {9'h000, `ESRG_SZ_512K};
         ESRG_SZ_1M_E:   size_bytes = {9'h000, `ESRG_SZ_1M};
         ESRG_SZ_2M_E:   size_bytes = {9'h000, `ESRG_SZ_2M};
         default:        size_bytes = {9'h000, `ESRG_SZ_4M};
      endcase
   end

   assign top_addr  = {1'b0, top, 28'h0000000}; // [RQ1]
   // A top of zero wraps; base below zero never matches
   assign base_addr = top_addr - size_bytes;
   assign hit = enable && (addr[39:32] == 8'h00) && !base_addr[32]
                && ({1'b0, addr[31:0]} >= base_addr)
                && ({1'b0, addr[31:0]} < top_addr); // [RQ2] [RQ12]
endmodule : esrg_decode

// ==== hw/esrg_guard.sv ====
// Extended SMM range guard with APB registers and violation monitor
`include "esrg_defines.svh"
// What this block does
// (RQ1) Four-bit top field gives address bits 31:28 of the exclusive bound.
// (RQ2) Decode hits only below 4GB, from top minus size up to top.
// (RQ3) Region size is 512 KB, 1 MB, 2 MB or 4 MB.
// (RQ4) Top field resets to one, the default low memory top.
// (RQ5) Top field is writable until the lock is set, then read-only.
// (RQ6) Software must never place top above the low memory top.
// (RQ7) Non-SMM processor access to guarded ranges without open sets flag.
// (RQ8) Inbound I/O access to SMM range, master-aborted, sets the flag.
// (RQ9) Eviction writebacks into SMM ranges never set the flag.
// (RQ10) Flag stays set until software writes one to bit 7.
// (RQ11) Size select 00/01/10/11 means 512K/1M/2M/4M.
// (RQ12) Region exists only with global and region enables both set.
// (RQ13) Only SMM-marked processor requests may reach the protected memory.
// (RQ14) Non-SMM hits in the region go to the south bridge port.
// (RQ15) Lock holds until system reset, keeping locked fields read-only.
module esrg_guard
   import esrg_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cpu_req,
   input  wire logic [39:0] cpu_addr,
   input  wire logic        smm_request_indicator,
   input  wire logic        explicit_eviction_writeback,
   input  wire logic        implicit_eviction_writeback,
   input  wire logic        high_smm_hit,
   output logic             cpu_to_south_bridge_port,
   output logic             cpu_to_dram,
   input  wire logic        io_req,
   input  wire logic [39:0] io_addr,
   output logic             io_master_abort,
   output logic             irq
);
   logic [3:0]  region_top_field_r;
   esrg_size_t  protected_size_select_r;
   logic        extended_region_enable_r;
   logic        global_smram_enable_r;
   logic        smram_open_r;
   logic        smram_lock_r;
   logic        smm_violation_flag_r;
   logic [1:0]  irq_stat_r;
   logic [1:0]  irq_en_r;
   logic        cpu_hit;
   logic        io_hit;
   logic        region_on;
   logic        cpu_evict;
   logic        cpu_viol;
   logic        io_viol;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic        clr_flag;
   logic [31:0] rdata_nxt;

   assign region_on = global_smram_enable_r
                      && extended_region_enable_r; // [RQ12]

   esrg_decode u_cpu_dec (
      .addr     (cpu_addr),
      .top      (region_top_field_r),
      .size_sel (protected_size_select_r),
      .enable   (region_on),
      .hit      (cpu_hit)
   );

   esrg_decode u_io_dec (
      .addr     (io_addr),
      .top      (region_top_field_r),
      .size_sel (protected_size_select_r),
      .enable   (region_on),
      .hit      (io_hit)
   );

   assign cpu_evict = explicit_eviction_writeback
                      || implicit_eviction_writeback;
   // Routing is combinational so the request path adds no latency
   assign cpu_to_south_bridge_port = cpu_req && cpu_hit
                                     && !smm_request_indicator; // [RQ14]
   assign cpu_to_dram = cpu_req && !(cpu_hit
                                     && !smm_request_indicator); // [RQ13]
   assign io_master_abort = io_req && io_hit; // [RQ8]

   // Evictions are exempt whatever the SMM indicator says
   assign cpu_viol = cpu_req && !cpu_evict && !smm_request_indicator
                     && !smram_open_r
                     && (cpu_hit || high_smm_hit); // [RQ7] [RQ9]
   assign io_viol  = io_master_abort; // [RQ8]

   // APB: zero wait states, error on unmapped offsets
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   always_comb begin
      addr_ok = 1'b1;
      if (paddr == `ESRG_OFF_TOP) begin
         addr_ok = 1'b1;
      end else if (paddr == `ESRG_OFF_ERR) begin
         addr_ok = 1'b1;
      end else if (paddr == `ESRG_OFF_CTRL) begin
         addr_ok = 1'b1;
      end else if (paddr == `ESRG_OFF_LOCK) begin
         addr_ok = 1'b1;
      end else if (paddr == `ESRG_OFF_IRQ_STAT) begin
         addr_ok = 1'b1;
      end else if (paddr == `ESRG_OFF_IRQ_EN) begin
         addr_ok = 1'b1;
      end else if (paddr == `ESRG_OFF_IRQ_CLR) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end
   assign pslverr = psel && penable && !addr_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         region_top_field_r <= `ESRG_TOP_RESET; // [RQ4]
      end else if (wr_en && paddr == `ESRG_OFF_TOP && !smram_lock_r) begin
         region_top_field_r <= pwdata[3:0]; // [RQ5]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         protected_size_select_r  <= ESRG_SZ_512K_E;
         extended_region_enable_r <= 1'b0;
         global_smram_enable_r    <= 1'b0;
         smram_open_r             <= 1'b0;
      end else if (wr_en && paddr == `ESRG_OFF_CTRL) begin
         // Open override stays writable; it is the SMM handler's door
         smram_open_r <= pwdata[`ESRG_CTRL_OPEN];
         if (!smram_lock_r) begin
            protected_size_select_r <= esrg_size_t'(
               pwdata[`ESRG_CTRL_SZ_HI:`ESRG_CTRL_SZ_LO]);
            extended_region_enable_r <= pwdata[`ESRG_CTRL_EN];
            global_smram_enable_r    <= pwdata[`ESRG_CTRL_GEN];
         end
      end
   end

   // Lock only sets; nothing but reset clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smram_lock_r <= 1'b0;
      end else if (wr_en && paddr == `ESRG_OFF_LOCK
                   && pwdata[`ESRG_LOCK_BIT]) begin
         smram_lock_r <= 1'b1; // [RQ15]
      end
   end

   assign clr_flag = wr_en && paddr == `ESRG_OFF_ERR
                     && pwdata[`ESRG_ERR_BIT];

   // Set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smm_violation_flag_r <= 1'b0;
      end else if (cpu_viol || io_viol) begin
         smm_violation_flag_r <= 1'b1; // [RQ7] [RQ8]
      end else if (clr_flag) begin
         smm_violation_flag_r <= 1'b0; // [RQ10]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= 2'h0;
      end else begin
         irq_stat_r[`ESRG_EV_CPU] <= cpu_viol || (irq_stat_r[`ESRG_EV_CPU]
            && !(wr_en && paddr == `ESRG_OFF_IRQ_CLR
                 && pwdata[`ESRG_EV_CPU]));
         irq_stat_r[`ESRG_EV_IO] <= io_viol || (irq_stat_r[`ESRG_EV_IO]
            && !(wr_en && paddr == `ESRG_OFF_IRQ_CLR
                 && pwdata[`ESRG_EV_IO]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_r <= 2'h0;
      end else if (wr_en && paddr == `ESRG_OFF_IRQ_EN) begin
         irq_en_r <= pwdata[1:0];
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);

   always_comb begin
      rdata_nxt = 32'h00000000;
      if (paddr == `ESRG_OFF_TOP) begin
         rdata_nxt[3:0] = region_top_field_r;
      end else if (paddr == `ESRG_OFF_ERR) begin
         rdata_nxt[`ESRG_ERR_BIT] = smm_violation_flag_r;
      end else if (paddr == `ESRG_OFF_CTRL) begin
         rdata_nxt[`ESRG_CTRL_EN] = extended_region_enable_r;
         rdata_nxt[`ESRG_CTRL_SZ_HI:`ESRG_CTRL_SZ_LO] =
            protected_size_select_r;
         rdata_nxt[`ESRG_CTRL_GEN]  = global_smram_enable_r;
         rdata_nxt[`ESRG_CTRL_OPEN] = smram_open_r;
      end else if (paddr == `ESRG_OFF_LOCK) begin
         rdata_nxt[`ESRG_LOCK_BIT] = smram_lock_r;
      end else if (paddr == `ESRG_OFF_IRQ_STAT) begin
         rdata_nxt[1:0] = irq_stat_r;
      end else if (paddr == `ESRG_OFF_IRQ_EN) begin
         rdata_nxt[1:0] = irq_en_r;
      end else begin
         rdata_nxt = 32'h00000000;
      end
   end

   // Read data captured in setup so it is stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         prdata <= rdata_nxt;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_top_locked: assert property ( // [RQ5] [RQ15]
      smram_lock_r |=> $stable(region_top_field_r) && smram_lock_r)
      else $error("top field changed while locked");

   chk_top_write: assert property ( // [RQ5]
      wr_en && paddr == `ESRG_OFF_TOP && !smram_lock_r
      |=> region_top_field_r == $past(pwdata[3:0]))
      else $error("top field write lost");

   chk_cpu_sets: assert property ( // [RQ7]
      cpu_req && cpu_hit && !smm_request_indicator && !cpu_evict
      && !smram_open_r |=> smm_violation_flag_r)
      else $error("cpu violation not flagged");

   chk_io_sets: assert property ( // [RQ8]
      io_req && io_hit |=> smm_violation_flag_r)
      else $error("io violation not flagged");

   sequence s_quiet;
      !cpu_viol && !io_viol;
   endsequence
   chk_evict_quiet: assert property ( // [RQ9]
      !smm_violation_flag_r && cpu_evict && !io_req
      |=> !smm_violation_flag_r)
      else $error("eviction set the flag");

   chk_flag_clear: assert property ( // [RQ10]
      clr_flag and s_quiet |=> !smm_violation_flag_r)
      else $error("flag not cleared by write one");

   chk_flag_sticky: assert property ( // [RQ10]
      smm_violation_flag_r && !clr_flag |=> smm_violation_flag_r)
      else $error("flag dropped without clear");

   chk_region_off: assert property ( // [RQ12]
      !(global_smram_enable_r && extended_region_enable_r)
      |-> !cpu_to_south_bridge_port && !io_master_abort)
      else $error("region active while disabled");

   chk_route_sb: assert property ( // [RQ13] [RQ14]
      cpu_to_south_bridge_port |-> !cpu_to_dram && !smm_request_indicator
      && cpu_addr[39:32] == 8'h00 && cpu_addr[31:28] <= region_top_field_r)
      else $error("bad south bridge routing");

   chk_ctrl_locked: assert property ( // [RQ15]
      smram_lock_r |=> $stable(protected_size_select_r)
      && $stable(extended_region_enable_r)
      && $stable(global_smram_enable_r))
      else $error("control fields changed while locked");

   chk_smm_to_dram: assert property ( // [RQ13]
      cpu_req && smm_request_indicator |-> cpu_to_dram
      && !cpu_to_south_bridge_port)
      else $error("SMM request kept from DRAM");

   chk_hit_to_sb: assert property ( // [RQ14]
      cpu_req && cpu_hit && !smm_request_indicator
      |-> cpu_to_south_bridge_port && !cpu_to_dram)
      else $error("non-SMM hit not sent to south bridge");

   // Lock write is a single-step event, kept as a named sequence
   sequence s_lock_write;
      wr_en && paddr == `ESRG_OFF_LOCK && pwdata[`ESRG_LOCK_BIT];
   endsequence
   chk_lock_sets: assert property ( // [RQ15]
      s_lock_write |=> smram_lock_r)
      else $error("lock write not taken");

   chk_event_status: assert property ( // [RQ7] [RQ8]
      cpu_viol || io_viol |=> irq_stat_r != 2'h0)
      else $error("violation not recorded in status");

   chk_open_quiet: assert property ( // [RQ7]
      smram_open_r && !io_req && !smm_violation_flag_r
      |=> !smm_violation_flag_r)
      else $error("open override access set the flag");
endmodule : esrg_guard

// ==== tb/esrg_fsb_model.sv ====
// Far side: processor bus requester and inbound I/O requester
module esrg_fsb_model (
   input  wire logic        pclk,
   output logic             cpu_req,
   output logic [39:0]      cpu_addr,
   output logic             smm_request_indicator,
   output logic             explicit_eviction_writeback,
   output logic             implicit_eviction_writeback,
   output logic             high_smm_hit,
   input  wire logic        cpu_to_south_bridge_port,
   input  wire logic        cpu_to_dram,
   output logic             io_req,
   output logic [39:0]      io_addr,
   input  wire logic        io_master_abort
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {cpu_req, cpu_addr, io_req, io_addr} = '0;
      {smm_request_indicator, high_smm_hit} = 2'h0;
      {explicit_eviction_writeback, implicit_eviction_writeback} = 2'h0;
   end
   // Kind bits: high SMM hit, implicit, explicit writeback, SMM request
   task automatic cpu_op(input logic [39:0] a, input logic [3:0] k,
                         output logic sb, output logic dr);
      @(posedge pclk);
      cpu_req <= 1'b1;
      cpu_addr <= a;
      {high_smm_hit, implicit_eviction_writeback,
       explicit_eviction_writeback, smm_request_indicator} <= k;
      @(negedge pclk);
      sb = cpu_to_south_bridge_port;
      dr = cpu_to_dram;
      @(posedge pclk);
      cpu_req <= 1'b0;
      // Idle bus must not keep a stale address
      cpu_addr <= ~a;
      {high_smm_hit, implicit_eviction_writeback,
       explicit_eviction_writeback, smm_request_indicator} <= 4'h0;
   endtask : cpu_op
   task automatic io_op(input logic [39:0] a, output logic ab);
      @(posedge pclk);
      io_req <= 1'b1;
      io_addr <= a;
      @(negedge pclk);
      ab = io_master_abort;
      @(posedge pclk);
      io_req <= 1'b0;
      io_addr <= ~a;
   endtask : io_op
endmodule : esrg_fsb_model

// ==== tb/esrg_guard_bench.sv ====
// Self-checking bench for the extended SMM range guard
`include "esrg_defines.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   num_errors++; $display("BAD %0t got %0h exp %0h", $time, a, e); end end
module esrg_guard_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        cpu_req, smm_request_indicator, high_smm_hit, irq;
   logic        explicit_eviction_writeback, implicit_eviction_writeback;
   logic        cpu_to_south_bridge_port, cpu_to_dram;
   logic        io_req, io_master_abort, sb, dr, ab, err;
   logic [39:0] cpu_addr, io_addr, lo, hi;
   int          num_errors = 0, samples_checked = 0, cycles = 0;
   esrg_guard esrg_guard_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_req, .cpu_addr,
      .smm_request_indicator, .explicit_eviction_writeback,
      .implicit_eviction_writeback, .high_smm_hit, .cpu_to_south_bridge_port,
      .cpu_to_dram, .io_req, .io_addr, .io_master_abort, .irq);
   esrg_fsb_model esrg_fsb_model_inst (.pclk, .cpu_req, .cpu_addr,
      .smm_request_indicator, .explicit_eviction_writeback,
      .implicit_eviction_writeback, .high_smm_hit, .cpu_to_south_bridge_port,
      .cpu_to_dram, .io_req, .io_addr, .io_master_abort);
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rdchk
   task automatic hit_chk(input logic [39:0] a, input logic h);
      esrg_fsb_model_inst.cpu_op(a, 4'h0, sb, dr);
      `CHK(sb, h)
      `CHK(dr, ~h)
   endtask : hit_chk
   task automatic irq_chk(input logic e);
      @(negedge pclk);
      `CHK(irq, e)
   endtask : irq_chk
   task automatic clear_all();
      apb(1'b1, `ESRG_OFF_ERR, 32'h80);
      apb(1'b1, `ESRG_OFF_IRQ_CLR, 32'h3);
      irq_chk(1'b0);
   endtask : clear_all
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`ESRG_OFF_TOP, 32'h1);
      rdchk(`ESRG_OFF_ERR, 32'h0);
      apb(1'b1, `ESRG_OFF_IRQ_EN, 32'h3);
      rdchk(`ESRG_OFF_IRQ_EN, 32'h3);
      `CHK(err, 1'b0)
      rdchk(`ESRG_OFF_IRQ_CLR, 32'h0);
      // Kept at or below the low memory top
      apb(1'b1, `ESRG_OFF_TOP, 32'h4);
      rdchk(`ESRG_OFF_TOP, 32'h4);
      hi = 40'h00_4000_0000;
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, `ESRG_OFF_CTRL, 32'h9 | 32'(s << 1));
         rdchk(`ESRG_OFF_CTRL, 32'h9 | 32'(s << 1));
         lo = hi - (40'h00_0008_0000 << s);
         hit_chk(lo, 1'b1);
         hit_chk(lo - 1, 1'b0);
         hit_chk(hi - 1, 1'b1);
         hit_chk(hi, 1'b0);
      end
      hit_chk({8'h01, lo[31:0]}, 1'b0);
      rdchk(`ESRG_OFF_ERR, 32'h80);
      rdchk(`ESRG_OFF_IRQ_STAT, 32'h1);
      irq_chk(1'b1);
      apb(1'b1, `ESRG_OFF_ERR, 32'h0);
      rdchk(`ESRG_OFF_ERR, 32'h80);
      clear_all();
      rdchk(`ESRG_OFF_ERR, 32'h0);
      esrg_fsb_model_inst.cpu_op(hi - 1, 4'h1, sb, dr);
      `CHK(dr, 1'b1)
      esrg_fsb_model_inst.cpu_op(hi - 1, 4'h2, sb, dr);
      esrg_fsb_model_inst.cpu_op(hi - 1, 4'h4, sb, dr);
      rdchk(`ESRG_OFF_ERR, 32'h0);
      esrg_fsb_model_inst.cpu_op(40'h0, 4'h8, sb, dr);
      rdchk(`ESRG_OFF_ERR, 32'h80);
      clear_all();
      apb(1'b1, `ESRG_OFF_CTRL, 32'h19);
      esrg_fsb_model_inst.cpu_op(hi - 1, 4'h0, sb, dr);
      rdchk(`ESRG_OFF_ERR, 32'h0);
      // Size back to 4 MB so lo is the region's lowest address again
      apb(1'b1, `ESRG_OFF_CTRL, 32'hF);
      esrg_fsb_model_inst.io_op(lo, ab);
      `CHK(ab, 1'b1)
      rdchk(`ESRG_OFF_ERR, 32'h80);
      rdchk(`ESRG_OFF_IRQ_STAT, 32'h2);
      irq_chk(1'b1);
      apb(1'b1, `ESRG_OFF_IRQ_EN, 32'h0);
      irq_chk(1'b0);
      clear_all();
      apb(1'b1, `ESRG_OFF_CTRL, 32'h1);
      hit_chk(hi - 1, 1'b0);
      esrg_fsb_model_inst.io_op(hi - 1, ab);
      `CHK(ab, 1'b0)
      rdchk(12'h020, 32'h0);
      `CHK(err, 1'b1)
      apb(1'b1, `ESRG_OFF_LOCK, 32'h1);
      rdchk(`ESRG_OFF_LOCK, 32'h1);
      apb(1'b1, `ESRG_OFF_TOP, 32'h2);
      rdchk(`ESRG_OFF_TOP, 32'h4);
      apb(1'b1, `ESRG_OFF_CTRL, 32'h1F);
      rdchk(`ESRG_OFF_CTRL, 32'h11);
      give_verdict();
   end
endmodule : esrg_guard_bench
